// ---- tb/bus_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_chk #(
  parameter ADDR_W = 16,
  parameter DATA_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Requests and pins in
  input wire logic clk_en,
  input wire logic irq_on_instr,
  input wire logic irq_off_instr,
  input wire logic ready_pin,
  // Pins and answers out
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic addr_oe,
  input wire logic cycle_start,
  input wire logic bus_input_strobe,
  input wire logic write_strobe_b,
  input wire logic stretch_ind,
  input wire logic phase1,
  input wire logic phase2,
  input wire logic bus_release_ack,
  input wire logic irq_enable_flag,
  input wire logic irq_taken,
  input wire logic [ADDR_W-1:0] pc_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  property p_rst_vals;
    $rose(rst_b) |-> pc_out == 0 && !irq_enable_flag && !bus_release_ack;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  // Ack comes first, float follows within a couple of phases
  property p_float;
    $rose(bus_release_ack) |-> ##[0:4] (!addr_oe && !data_oe);
  endproperty
  a_float: assert property (p_float) else $error("buses not floated");
  // Ack rises with phase one, the buses let go with phase two
  property p_ack_ph1;
    $rose(bus_release_ack) |-> phase1 && !phase2;
  endproperty
  a_ack_ph1: assert property (p_ack_ph1) else $error("ack off phase one");
  property p_float_ph2;
    $fell(addr_oe) |-> phase2 && bus_release_ack;
  endproperty
  a_float_ph2: assert property (p_float_ph2) else $error("float off phase two");
  property p_ack_late;
    $rose(bus_release_ack) |-> write_strobe_b;
  endproperty
  a_ack_late: assert property (p_ack_late) else $error("ack during write");
  property p_wr_hold;
    !write_strobe_b && $past(!write_strobe_b) |-> data_oe && $stable(data_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data moved");
  property p_in_mode;
    bus_input_strobe |-> !data_oe && write_strobe_b;
  endproperty
  a_in_mode: assert property (p_in_mode) else $error("drive in input mode");
  property p_start;
    cycle_start |-> data_oe ##1 !cycle_start;
  endproperty
  a_start: assert property (p_start) else $error("cycle start wrong");
  // Ready high long enough means no stretch may stand
  property p_no_stretch;
    ready_pin [*8] |-> !stretch_ind;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("stray stretch");
  property p_irq_on;
    irq_on_instr && !irq_off_instr && clk_en |-> ##[1:4] irq_enable_flag;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enable flag not set");
  property p_irq_clr;
    irq_taken |-> ##[0:4] !irq_enable_flag;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("flag not cleared");
  property p_irq_hold;
    irq_taken |-> !bus_release_ack;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq taken in takeover");
  c_ack: cover property ($rose(bus_release_ack));
  c_stretch: cover property (stretch_ind);
  c_irq: cover property (irq_taken);
endmodule
bind cpu_bus_control_unit bus_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .irq_on_instr(irq_on_instr),
  .irq_off_instr(irq_off_instr), .ready_pin(ready_pin), .data_out(data_out),
  .data_oe(data_oe), .addr_oe(addr_oe), .cycle_start(cycle_start),
  .bus_input_strobe(bus_input_strobe), .write_strobe_b(write_strobe_b),
  .stretch_ind(stretch_ind), .phase1(phase1), .phase2(phase2),
  .bus_release_ack(bus_release_ack),
  .irq_enable_flag(irq_enable_flag), .irq_taken(irq_taken), .pc_out(pc_out)
);
`default_nettype wire

// ---- tb/bus_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  // Clock and speed
  input wire logic core_clk,
  input wire logic [3:0] slow,
  // Device pins
  input wire logic [15:0] addr_out,
  input wire logic [7:0] data_out,
  input wire logic cycle_start,
  input wire logic bus_input_strobe,
  input wire logic write_strobe_b,
  output logic ready_pin,
  output logic [7:0] data_in
);
  logic [7:0] mem [0:255]; // Only the low address byte decodes
  logic [3:0] wait_cnt = 4'h0; // Clocks left before data is good
  initial begin
    data_in = 8'h00;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  assign ready_pin = (wait_cnt == 4'h0);
  ////////////////////////////////////////////////////////////////
  // Undriven bus toggles so a stale value never reads as good
  always @(posedge core_clk) begin
    if (cycle_start) wait_cnt <= slow;
    else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
    if (bus_input_strobe) data_in <= mem[addr_out[7:0]];
    else data_in <= ~data_in;
    if (!write_strobe_b) mem[addr_out[7:0]] <= data_out;
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Bench-driven inputs
  logic core_clk = 1'b0;
  logic clk_en = 1'b1;
  logic rst_b = 1'b0;
  logic cycle_req = 1'b0;
  logic [2:0] cycle_kind = 3'h0;
  logic [15:0] cycle_addr = 16'h0000;
  logic [7:0] cycle_wdata = 8'h00;
  logic use_pc = 1'b0;
  logic instr_end = 1'b0;
  logic halt_req = 1'b0;
  logic irq_on_instr = 1'b0;
  logic irq_off_instr = 1'b0;
  logic hold_pin = 1'b0;
  logic irq_pin = 1'b0;
  logic [3:0] slow = 4'h0;
  // Device outputs
  wire [7:0] rdata, data_in, data_out;
  wire [15:0] pc_out, addr_out;
  wire rdata_valid, cycle_done, irq_taken, ready_pin, data_oe, addr_oe, cycle_start;
  wire bus_input_strobe, write_strobe_b, stretch_ind, bus_release_ack, irq_enable_flag;
  int fails = 0;
  int comparisons = 0;
  int nstretch = 0;
  int nirq = 0;
  typedef struct {logic [2:0] k; logic [15:0] a; logic [7:0] d, st, rd;} row_t;
  // Kind, address, write data, status word, read data
  row_t rows [6] = '{'{3'h2, 16'h0240, 8'ha5, 8'h00, 8'h00},
    '{3'h3, 16'h0707, 8'h00, 8'h42, 8'h5d}, '{3'h4, 16'h0909, 8'h3c, 8'h10, 8'h00},
    '{3'h1, 16'h1234, 8'h00, 8'h82, 8'h6e}, '{3'h1, 16'h0240, 8'h00, 8'h82, 8'ha5},
    '{3'h0, 16'h0311, 8'h00, 8'ha2, 8'h00}};
  always #2 core_clk = ~core_clk;
  cpu_bus_control_unit dut_u (
    .core_clk(core_clk), .clk_en(clk_en), .rst_b(rst_b), .cycle_req(cycle_req),
    .cycle_kind(cycle_kind), .cycle_addr(cycle_addr), .cycle_wdata(cycle_wdata),
    .use_pc(use_pc), .instr_end(instr_end), .halt_req(halt_req),
    .irq_on_instr(irq_on_instr), .irq_off_instr(irq_off_instr), .rdata(rdata),
    .rdata_valid(rdata_valid), .cycle_done(cycle_done), .irq_taken(irq_taken),
    .pc_out(pc_out), .ready_pin(ready_pin), .hold_pin(hold_pin), .irq_pin(irq_pin),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .addr_out(addr_out),
    .addr_oe(addr_oe), .phase1(), .phase2(), .cycle_start(cycle_start),
    .bus_input_strobe(bus_input_strobe), .write_strobe_b(write_strobe_b),
    .stretch_ind(stretch_ind), .bus_release_ack(bus_release_ack),
    .irq_enable_flag(irq_enable_flag)
  );
  bus_partner part_u (
    .core_clk(core_clk), .slow(slow), .addr_out(addr_out), .data_out(data_out),
    .cycle_start(cycle_start), .bus_input_strobe(bus_input_strobe),
    .write_strobe_b(write_strobe_b), .ready_pin(ready_pin), .data_in(data_in)
  );
  ////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (stretch_ind === 1'b1) nstretch++;
    if (irq_taken === 1'b1) nirq++;
  end
  task automatic summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return cycle_start;
      1: return cycle_done;
      2: return rdata_valid;
      3: return bus_release_ack;
      default: return !bus_release_ack;
    endcase
  endfunction
  // Bounded wait; cycle starts must also show the wanted address
  task automatic wait_hi(input int w, input logic [15:0] a);
    int n;
    n = 0;
    @(posedge core_clk);
    while (!(sig(w) === 1'b1 && (w != 0 || addr_out === a))) begin
      n++;
      if (n > 300) begin
        chk("wait", 16'(w), 16'hffff);
        summarize();
      end
      @(posedge core_clk);
    end
  endtask
  task automatic run(input row_t r);
    cycle_kind <= r.k;
    cycle_addr <= r.a;
    cycle_wdata <= r.d;
    cycle_req <= 1'b1;
    wait_hi(0, r.a);
    chk("status", {8'h00, r.st}, {8'h00, data_out});
    if (r.k == 3'h1 || r.k == 3'h3) begin
      wait_hi(2, 16'h0000);
      chk("rdata", {8'h00, r.rd}, {8'h00, rdata});
    end
    wait_hi(1, 16'h0000);
  endtask
  // Pulse one datapath request: 0 end, 1 enable, 2 disable
  task automatic pulse(input int w);
    if (w == 0) instr_end <= 1'b1;
    else if (w == 1) irq_on_instr <= 1'b1;
    else irq_off_instr <= 1'b1;
    @(posedge core_clk);
    instr_end <= 1'b0;
    irq_on_instr <= 1'b0;
    irq_off_instr <= 1'b0;
    repeat (24) @(posedge core_clk);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk("pc", 16'h0000, pc_out);
    chk("flags", 16'h0000, {14'h0, bus_release_ack, irq_enable_flag});
    wait_hi(0, 16'h0000);
    chk("fetch0", 16'h00a2, {8'h00, data_out});
    for (int i = 0; i < 6; i++) run(rows[i]);
    chk("nostretch", 16'h0000, 16'(nstretch));
    slow <= 4'ha;
    run(rows[3]);
    chk("stretch", 16'h0001, {15'h0, nstretch != 0});
    slow <= 4'h0;
    // Takeover requested while a write is under way
    cycle_kind <= 3'h2;
    cycle_addr <= 16'h0555;
    cycle_wdata <= 8'hc3;
    wait_hi(0, 16'h0555);
    hold_pin <= 1'b1;
    wait_hi(3, 16'h0000);
    repeat (4) @(posedge core_clk);
    chk("float", 16'h0000, {14'h0, addr_oe, data_oe});
    chk("wrmem", 16'h00c3, {8'h00, part_u.mem[8'h55]});
    hold_pin <= 1'b0;
    wait_hi(4, 16'h0000);
    irq_pin <= 1'b1;
    pulse(0);
    pulse(0);
    chk("irqoff", 16'h0000, 16'(nirq));
    pulse(1);
    chk("flagon", 16'h0001, {15'h0, irq_enable_flag});
    pulse(0);
    chk("early", 16'h0000, 16'(nirq));
    pulse(0);
    chk("taken", 16'h0001, 16'(nirq));
    chk("flagclr", 16'h0000, {15'h0, irq_enable_flag});
    irq_pin <= 1'b0;
    pulse(1);
    pulse(2);
    chk("flagoff", 16'h0000, {15'h0, irq_enable_flag});
    summarize();
  end
endmodule
`default_nettype wire

// ---- verilog/bus_ctrl_defines.vh ----
`ifndef BUS_CTRL_DEFINES_VH
`define BUS_CTRL_DEFINES_VH
// Machine cycle state codes
`define ST_FIRST 3'h0
`define ST_SECOND 3'h1
`define ST_STRETCH 3'h2
`define ST_THIRD 3'h3
`define ST_FOURTH 3'h4
`define ST_HALT 3'h5
`define ST_HOLD 3'h6
// Cycle kind codes
`define CYC_FETCH 3'h0
`define CYC_MEM_RD 3'h1
`define CYC_MEM_WR 3'h2
`define CYC_IN 3'h3
`define CYC_OUT 3'h4
`define CYC_IRQ_ACK 3'h5
`define CYC_HALT 3'h6
// Status word bit positions
`define STAT_INTA 0
`define STAT_WO_B 1
`define STAT_STACK 2
`define STAT_HLTA 3
`define STAT_OUT 4
`define STAT_M1 5
`define STAT_INP 6
`define STAT_MEMR 7
// Reset values
`define PC_RESET 16'h0000
// Phase divider: core clocks per two-phase clock period
`define PHASE_CLKS 2'h2
`endif

// ---- verilog/cpu_bus_control_unit.v ----
`timescale 1ns/1ps
`default_nettype none
`include "bus_ctrl_defines.vh"
// Summary of operation
// RULE1: Drive 16-bit memory or port address
// RULE2: Status word on data bus at cycle start
// RULE3: Reset clears program counter to zero
// RULE4: Reset clears irq enable and release ack
// RULE5: Reset held at least three clock periods
// RULE6: Takeover seen when halted or second/stretch ready
// RULE7: Release buses only after cycle's use
// RULE8: Float buses and assert release ack
// RULE9: Ack in third state reads, after writes
// RULE10: Ack on phase one, float on phase two
// RULE11: Sample interrupt at instruction end or halted
// RULE12: Ignore interrupt in takeover or disabled
// RULE13: Enable flag set/cleared by instructions, output
// RULE14: Accepted interrupt clears flag in first state
// RULE15: Accept multi-byte instruction from data bus
// RULE16: Input strobe marks input mode
// RULE17: Low write strobe with data held valid
// RULE18: Pulse cycle-start marker each machine cycle
// RULE19: Stretch while ready is low
// RULE20: Wait indicator throughout each stretch state
// RULE21: Interrupt accepted two instructions after enable
// RULE22: First, second, stretch, third, further states
module cpu_bus_control_unit #(
  parameter ADDR_W = 16,
  parameter DATA_W = 8
) (
  // Clock, enable, reset
  input wire core_clk,
  input wire clk_en,
  input wire rst_b,
  // Sequencer requests from the datapath
  input wire cycle_req,
  input wire [2:0] cycle_kind,
  input wire [ADDR_W-1:0] cycle_addr,
  input wire [DATA_W-1:0] cycle_wdata,
  input wire use_pc,
  input wire instr_end,
  input wire halt_req,
  input wire irq_on_instr,
  input wire irq_off_instr,
  // Datapath answers
  output reg [DATA_W-1:0] rdata,
  output reg rdata_valid,
  output reg cycle_done,
  output reg irq_taken,
  output reg [ADDR_W-1:0] pc_out,
  // External pins
  input wire ready_pin,
  input wire hold_pin,
  input wire irq_pin,
  input wire [DATA_W-1:0] data_in,
  output reg [DATA_W-1:0] data_out,
  output reg data_oe,
  output reg [ADDR_W-1:0] addr_out,
  output reg addr_oe,
  output reg phase1,
  output reg phase2,
  output reg cycle_start,
  output reg bus_input_strobe,
  output reg write_strobe_b,
  output reg stretch_ind,
  output reg bus_release_ack,
  output reg irq_enable_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change counts when stages 2 and 3 agree
  reg [2:0] ready_sync_reg;
  reg [2:0] hold_sync_reg;
  reg [2:0] irq_sync_reg;
  reg ready_f_reg;
  reg hold_f_reg;
  reg irq_f_reg;

  // Shift chains and filtered levels. They run through reset on purpose: a
  // chain cleared to low would read an idle-high ready pin as not ready and
  // force a stray stretch into the first fetch after release.
  always @(posedge core_clk) begin
    if (clk_en) begin
      ready_sync_reg <= {ready_sync_reg[1:0], ready_pin};
      hold_sync_reg <= {hold_sync_reg[1:0], hold_pin};
      irq_sync_reg <= {irq_sync_reg[1:0], irq_pin};
      // Update filtered level only when the two settled stages agree
      if (ready_sync_reg[1] == ready_sync_reg[2]) begin
        ready_f_reg <= ready_sync_reg[2];
      end
      if (hold_sync_reg[1] == hold_sync_reg[2]) begin
        hold_f_reg <= hold_sync_reg[2];
      end
      if (irq_sync_reg[1] == irq_sync_reg[2]) begin
        irq_f_reg <= irq_sync_reg[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-phase clock: each state is PHASE_CLKS core clocks, phase 1 then 2
  reg [1:0] ph_cnt_reg;
  wire ph_last = (ph_cnt_reg == `PHASE_CLKS - 2'h1);
  wire ph_first = (ph_cnt_reg == 2'h0);

  // Phase counter wraps once per state
  always @(posedge core_clk) begin
    if (!rst_b) begin
      ph_cnt_reg <= 2'h0;
      phase1 <= 1'b0;
      phase2 <= 1'b0;
    end else if (clk_en) begin
      ph_cnt_reg <= ph_last ? 2'h0 : ph_cnt_reg + 2'h1;
      phase1 <= ph_last;
      phase2 <= ph_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle state machine
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] kind_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [DATA_W-1:0] wdata_reg;
  reg [ADDR_W-1:0] pc_reg;
  reg hold_pend_reg;
  reg [1:0] ei_delay_reg;
  reg irq_ack_pend_reg;
  // Status word for the current cycle kind
  wire [7:0] status_word;
  status_word_gen u_status (
    .cyc_kind(kind_reg),
    .status(status_word)
  );

  // Decode used several times: does this cycle kind write the bus
  function is_write;
    input [2:0] k;
    begin
      is_write = (k == `CYC_MEM_WR) || (k == `CYC_OUT);
    end
  endfunction

  // Decode: does this cycle kind read the bus
  function is_read;
    input [2:0] k;
    begin
      is_read = (k == `CYC_FETCH) || (k == `CYC_MEM_RD) || (k == `CYC_IN) ||
                (k == `CYC_IRQ_ACK);
    end
  endfunction

  // Takeover recognised only when halted or in second/stretch with ready
  wire hold_seen = hold_f_reg &&
                   ((state_reg == `ST_HALT) ||
                    (((state_reg == `ST_SECOND) || (state_reg == `ST_STRETCH)) &&
                     ready_f_reg)); // RULE6
  // Interrupt can be taken at instruction end or while halted
  wire irq_ok = irq_f_reg && irq_enable_flag && (ei_delay_reg == 2'h0) &&
                (state_reg != `ST_HOLD); // RULE12 RULE21

  // Next state, one step per state period
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ST_FIRST: state_next = `ST_SECOND; // RULE22
      `ST_SECOND, `ST_STRETCH: begin
        // Stretch while ready is low
        if (!ready_f_reg) begin
          state_next = `ST_STRETCH; // RULE19
        end else if (kind_reg == `CYC_HALT) begin
          state_next = `ST_HALT;
        end else begin
          state_next = `ST_THIRD;
        end
      end
      `ST_THIRD: begin
        // Writes finish their strobe first; a takeover then waits a period
        if (hold_pend_reg && is_write(kind_reg)) begin
          state_next = `ST_FOURTH; // RULE9
        end else if (hold_pend_reg) begin
          state_next = `ST_HOLD; // RULE7
        end else begin
          state_next = `ST_FIRST;
        end
      end
      `ST_FOURTH: state_next = hold_f_reg ? `ST_HOLD : `ST_FIRST;
      `ST_HALT: begin
        if (hold_seen) begin
          state_next = `ST_HOLD;
        end else if (irq_ok) begin
          state_next = `ST_FIRST; // RULE11
        end
      end
      `ST_HOLD: state_next = hold_f_reg ? `ST_HOLD : `ST_FIRST;
      default: state_next = `ST_FIRST;
    endcase
  end

  // State and cycle bookkeeping, advanced at the end of each state period
  always @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= `ST_FIRST;
      kind_reg <= `CYC_FETCH;
      addr_reg <= `PC_RESET;
      wdata_reg <= 8'h00;
      pc_reg <= `PC_RESET; // RULE3
      hold_pend_reg <= 1'b0; // RULE4
      irq_enable_flag <= 1'b0; // RULE4
      ei_delay_reg <= 2'h0;
      irq_ack_pend_reg <= 1'b0;
      irq_taken <= 1'b0;
      cycle_done <= 1'b0;
      pc_out <= `PC_RESET;
    end else if (clk_en) begin
      irq_taken <= 1'b0;
      cycle_done <= 1'b0;
      // Instruction enable/disable of interrupts. The end of the enabling
      // instruction itself is skipped, so the one after it still completes
      if (irq_on_instr) begin
        irq_enable_flag <= 1'b1; // RULE13
        ei_delay_reg <= 2'h1; // RULE21
      end else if (irq_off_instr) begin
        irq_enable_flag <= 1'b0; // RULE13
      end else if (instr_end && ei_delay_reg != 2'h0) begin
        ei_delay_reg <= ei_delay_reg - 2'h1;
      end
      // Interrupt sampled only at instruction end or when halted
      if (instr_end && irq_ok && !irq_ack_pend_reg) begin
        irq_ack_pend_reg <= 1'b1; // RULE11
      end
      if (ph_last) begin
        if (hold_seen) begin
          hold_pend_reg <= 1'b1;
        end else if (!hold_f_reg) begin
          hold_pend_reg <= 1'b0;
        end
        state_reg <= state_next;
        if (state_reg == `ST_HALT && irq_ok && !hold_seen) begin
          irq_ack_pend_reg <= 1'b1;
        end
        // Start a new cycle on entering the first state
        if (state_next == `ST_FIRST && state_reg != `ST_FIRST) begin
          if (irq_ack_pend_reg || (state_reg == `ST_HALT)) begin
            // Vector instruction bytes come from the interrupting logic
            kind_reg <= `CYC_IRQ_ACK; // RULE15
            addr_reg <= pc_reg;
            irq_enable_flag <= 1'b0; // RULE14
            irq_ack_pend_reg <= 1'b0;
            irq_taken <= 1'b1;
          end else if (cycle_req) begin
            kind_reg <= halt_req ? `CYC_HALT : cycle_kind;
            addr_reg <= use_pc ? pc_reg : cycle_addr; // RULE1
            wdata_reg <= cycle_wdata;
            if (use_pc && !halt_req) begin
              pc_reg <= pc_reg + 16'h0001;
            end
          end else begin
            kind_reg <= `CYC_FETCH;
            addr_reg <= pc_reg;
            pc_reg <= pc_reg + 16'h0001;
          end
        end
        if (state_reg == `ST_THIRD) begin
          cycle_done <= 1'b1;
        end
      end
      pc_out <= pc_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive, registered
  wire in_grant = (state_reg == `ST_HOLD);
  wire rd_kind = is_read(kind_reg);
  wire wr_kind = is_write(kind_reg);
  wire data_phase = (state_reg == `ST_SECOND) || (state_reg == `ST_STRETCH) ||
                    (state_reg == `ST_THIRD);
  // Ack rises with phase 1 of the state; float follows on phase 2
  wire ack_now = (hold_pend_reg && rd_kind && state_reg == `ST_THIRD) ||
                 (hold_pend_reg && state_reg == `ST_FOURTH) || in_grant; // RULE9

  // Outputs update every core clock from current state; ack and write strobe only at state end, from next state
  always @(posedge core_clk) begin
    if (!rst_b) begin
      addr_out <= `PC_RESET;
      addr_oe <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      cycle_start <= 1'b0;
      bus_input_strobe <= 1'b0;
      write_strobe_b <= 1'b1;
      stretch_ind <= 1'b0;
      bus_release_ack <= 1'b0; // RULE4
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
    end else if (clk_en) begin
      rdata_valid <= 1'b0;
      // Ack set at phase 1 of its state, held through the grant
      if (ph_last) begin
        // A read takeover is seen on this very edge, so the live request is
        // used: the pending flag would only land with the third state
        bus_release_ack <= (state_next == `ST_HOLD) ||
                           (hold_seen && rd_kind && state_next == `ST_THIRD) ||
                           (state_next == `ST_FOURTH); // RULE9 RULE10
        // Write strobe spans exactly the third state, in step with the ack,
        // so the strobe is already high when a write's takeover ack rises
        write_strobe_b <= !(wr_kind && state_next == `ST_THIRD); // RULE17
      end
      // Buses float once ack stands and phase 2 arrives, and stay floated
      // for the rest of the grant instead of being picked up again
      if (bus_release_ack && ack_now && (ph_first || !addr_oe)) begin
        addr_oe <= 1'b0; // RULE8 RULE10
        data_oe <= 1'b0; // RULE8
      end else if (!in_grant && state_reg != `ST_HALT) begin
        addr_oe <= 1'b1;
        addr_out <= addr_reg; // RULE1
        // Status in first state, write data during write, else released
        if (state_reg == `ST_FIRST) begin
          data_oe <= 1'b1;
          data_out <= status_word; // RULE2
        end else if (wr_kind && (data_phase || state_reg == `ST_FOURTH)) begin
          data_oe <= 1'b1;
          data_out <= wdata_reg; // RULE17
        end else begin
          data_oe <= 1'b0;
        end
      end else if (!in_grant) begin
        data_oe <= 1'b0;
      end
      // Marker pulse in the second phase of every first state
      cycle_start <= (state_reg == `ST_FIRST) && ph_first; // RULE18
      // Input strobe across the read data states; partner drives only then
      bus_input_strobe <= rd_kind && data_phase && !in_grant; // RULE16
      stretch_ind <= (state_reg == `ST_STRETCH); // RULE20
      // Capture input data at the end of the third state
      if (rd_kind && state_reg == `ST_THIRD && ph_last) begin
        rdata <= data_in; // RULE15
        rdata_valid <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- verilog/status_word_gen.v ----
`timescale 1ns/1ps
`default_nettype none
`include "bus_ctrl_defines.vh"
module status_word_gen (
  // Cycle kind in
  input wire [2:0] cyc_kind,
  // Status word out
  output reg [7:0] status
);
  // Decode the cycle kind into the status bits placed on the data bus
  always @* begin
    status = 8'h00;
    status[`STAT_WO_B] = 1'b1;
    case (cyc_kind)
      `CYC_FETCH: begin
        status[`STAT_M1] = 1'b1;
        status[`STAT_MEMR] = 1'b1;
      end
      `CYC_MEM_RD: status[`STAT_MEMR] = 1'b1;
      `CYC_MEM_WR: status[`STAT_WO_B] = 1'b0;
      `CYC_IN: status[`STAT_INP] = 1'b1;
      `CYC_OUT: begin
        status[`STAT_OUT] = 1'b1;
        status[`STAT_WO_B] = 1'b0;
      end
      `CYC_IRQ_ACK: begin
        status[`STAT_INTA] = 1'b1;
        status[`STAT_M1] = 1'b1;
      end
      `CYC_HALT: begin
        status[`STAT_HLTA] = 1'b1;
        status[`STAT_MEMR] = 1'b1;
      end
      default: status = 8'h02;
    endcase
  end
endmodule
`default_nettype wire
